// ---- src/acgr_regs_map.vh ----
// Register offsets, reset values and widths for the adaptive clock register bank.
// Assumes an 8-bit microcontroller data bus with 16-bit byte addresses.
// What this block does
// [RL1] The first synthesizer gets a 24-bit frequency word built from three byte registers.
// [RL2] The lowest address of a frequency triple holds bits 23:16, the next 15:8, the highest 7:0.
// [RL3] Every frequency byte can be read and written by the microcontroller and resets to zero.
// [RL4] The first word sets the codec master clock frequency when that synthesizer is selected.
// [RL5] The second synthesizer's output can serve as the other source of the codec master clock.
// [RL6] A 16-bit free-running counter advances once per codec master clock cycle.
// [RL7] At every USB start of frame the counter value is latched into the capture registers.
// [RL8] The counter's clock can be taken from either the primary or the second master clock.
// [RL9] The capture shows in two read-only bytes, high byte at the lower address, both reset to zero.
// [RL10] The second synthesizer has its own 24-bit word from three writable bytes, low bytes higher up.
// [RL11] The top byte of the second word sits in a writable register just below its middle byte.
// [RL12] The counter wraps silently, and the frame pulse is aligned to the counter's time base.
`ifndef ACGR_REGS_MAP_VH
`define ACGR_REGS_MAP_VH

`define ACGR_ADDR_W         16
`define ACGR_DATA_W         8
`define ACGR_CNT_W          16
`define ACGR_FRQ_W          24

`define ACGR_CAP_HIGH_ADDR  16'hFFE3
`define ACGR_CAP_LOW_ADDR   16'hFFE4
`define ACGR_S1_HIGH_ADDR   16'hFFE5
`define ACGR_S1_MID_ADDR    16'hFFE6
`define ACGR_S1_LOW_ADDR    16'hFFE7
`define ACGR_S2_HIGH_ADDR   16'hFFF7
`define ACGR_S2_MID_ADDR    16'hFFF8
`define ACGR_S2_LOW_ADDR    16'hFFF9

`define ACGR_BYTE_RST       8'h00
`define ACGR_CNT_RST        16'h0000
`define ACGR_CNT_ONE        16'h0001
`define ACGR_UNMAPPED_DATA  8'h00

`endif

// ---- src/acgr_regs.v ----
// Adaptive clock generator register bank: frequency words and frame count capture.
// Assumes the microcontroller bus and the frame pulse run on sys_clk_i; master clocks are pins.
`timescale 1ns/10ps
`include "acgr_regs_map.vh"

module acgr_regs
(
	input  wire                      sys_clk_i,
	input  wire                      reset_i,
	input  wire [`ACGR_ADDR_W-1:0]   bus_addr_i,
	input  wire                      bus_wr_i,
	input  wire [`ACGR_DATA_W-1:0]   bus_wdata_i,
	output reg  [`ACGR_DATA_W-1:0]   bus_rdata_o,
	input  wire                      usb_sof_i,
	input  wire                      primary_codec_clock_out_i,
	input  wire                      second_codec_clock_out_i,
	input  wire                      count_clk_sel_i,
	output reg  [`ACGR_FRQ_W-1:0]    first_adaptive_synth_freq_word_o,
	output reg  [`ACGR_FRQ_W-1:0]    second_adaptive_synth_freq_word_o,
	output reg  [`ACGR_CNT_W-1:0]    frame_count_latch_o
);

	//--------------------------------------------------------------
	// Storage
	//--------------------------------------------------------------
	reg [`ACGR_DATA_W-1:0] s1_high_q;
	reg [`ACGR_DATA_W-1:0] s1_mid_q;
	reg [`ACGR_DATA_W-1:0] s1_low_q;
	reg [`ACGR_DATA_W-1:0] s2_high_q;
	reg [`ACGR_DATA_W-1:0] s2_mid_q;
	reg [`ACGR_DATA_W-1:0] s2_low_q;
	reg [`ACGR_CNT_W-1:0]  count_q;
	reg [`ACGR_CNT_W-1:0]  count_d;
	reg [`ACGR_CNT_W-1:0]  latch_q;
	reg [1:0]              mclk_meta_q;
	reg [1:0]              mclk_sync_q;
	reg                    mclk_prev_q;
	reg [`ACGR_DATA_W-1:0] rdata_d;
	wire                   mclk_sel;
	wire                   mclk_rise;

	function hit;
		input [`ACGR_ADDR_W-1:0] addr;
		input [`ACGR_ADDR_W-1:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	//--------------------------------------------------------------
	// Frequency byte registers
	//--------------------------------------------------------------
	always @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			s1_high_q <= `ACGR_BYTE_RST; // [RL3]
			s1_mid_q  <= `ACGR_BYTE_RST; // [RL3]
			s1_low_q  <= `ACGR_BYTE_RST; // [RL3]
			s2_high_q <= `ACGR_BYTE_RST; // [RL11]
			s2_mid_q  <= `ACGR_BYTE_RST; // [RL10]
			s2_low_q  <= `ACGR_BYTE_RST; // [RL10]
		end
		else if (bus_wr_i)
		begin
			if (hit(bus_addr_i, `ACGR_S1_HIGH_ADDR))
				s1_high_q <= bus_wdata_i; // [RL3]
			if (hit(bus_addr_i, `ACGR_S1_MID_ADDR))
				s1_mid_q <= bus_wdata_i; // [RL3]
			if (hit(bus_addr_i, `ACGR_S1_LOW_ADDR))
				s1_low_q <= bus_wdata_i; // [RL3]
			if (hit(bus_addr_i, `ACGR_S2_HIGH_ADDR))
				s2_high_q <= bus_wdata_i; // [RL11]
			if (hit(bus_addr_i, `ACGR_S2_MID_ADDR))
				s2_mid_q <= bus_wdata_i; // [RL10]
			if (hit(bus_addr_i, `ACGR_S2_LOW_ADDR))
				s2_low_q <= bus_wdata_i; // [RL10]
		end
	end

	//--------------------------------------------------------------
	// Word outputs to the synthesizers
	//--------------------------------------------------------------
	// Registered so the synthesizers never see a half-written byte mid-cycle
	always @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			first_adaptive_synth_freq_word_o  <= {3{`ACGR_BYTE_RST}};
			second_adaptive_synth_freq_word_o <= {3{`ACGR_BYTE_RST}};
		end
		else
		begin
			first_adaptive_synth_freq_word_o  <= {s1_high_q, s1_mid_q, s1_low_q}; // [RL1] [RL2] [RL4]
			second_adaptive_synth_freq_word_o <= {s2_high_q, s2_mid_q, s2_low_q}; // [RL10] [RL5]
		end
	end

	//--------------------------------------------------------------
	// Master clock sampling
	//--------------------------------------------------------------
	// Master clocks must stay below half of sys_clk_i or edges are missed
	always @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			mclk_meta_q <= 2'h0;
			mclk_sync_q <= 2'h0;
			mclk_prev_q <= 1'b0;
		end
		else
		begin
			mclk_meta_q <= {second_codec_clock_out_i, primary_codec_clock_out_i};
			mclk_sync_q <= mclk_meta_q;
			mclk_prev_q <= mclk_sel;
		end
	end

	assign mclk_sel  = count_clk_sel_i ? mclk_sync_q[1] : mclk_sync_q[0]; // [RL8]
	assign mclk_rise = mclk_sel & ~mclk_prev_q;

	//--------------------------------------------------------------
	// Free-running counter and frame capture
	//--------------------------------------------------------------
	always @*
	begin
		count_d = count_q;
		if (mclk_rise)
			count_d = count_q + `ACGR_CNT_ONE; // [RL6] [RL12]
	end

	always @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			count_q             <= `ACGR_CNT_RST;
			latch_q             <= `ACGR_CNT_RST; // [RL9]
			frame_count_latch_o <= `ACGR_CNT_RST;
		end
		else
		begin
			count_q <= count_d;
			// Frame pulse shares the counter's time base, so no extra crossing
			if (usb_sof_i)
				latch_q <= count_q; // [RL7] [RL12]
			frame_count_latch_o <= latch_q;
		end
	end

	//--------------------------------------------------------------
	// Read path
	//--------------------------------------------------------------
	always @*
	begin
		rdata_d = `ACGR_UNMAPPED_DATA;
		if (hit(bus_addr_i, `ACGR_CAP_HIGH_ADDR))
			rdata_d = latch_q[15:8]; // [RL9]
		else if (hit(bus_addr_i, `ACGR_CAP_LOW_ADDR))
			rdata_d = latch_q[7:0]; // [RL9]
		else if (hit(bus_addr_i, `ACGR_S1_HIGH_ADDR))
			rdata_d = s1_high_q; // [RL3]
		else if (hit(bus_addr_i, `ACGR_S1_MID_ADDR))
			rdata_d = s1_mid_q;
		else if (hit(bus_addr_i, `ACGR_S1_LOW_ADDR))
			rdata_d = s1_low_q;
		else if (hit(bus_addr_i, `ACGR_S2_HIGH_ADDR))
			rdata_d = s2_high_q; // [RL11]
		else if (hit(bus_addr_i, `ACGR_S2_MID_ADDR))
			rdata_d = s2_mid_q;
		else if (hit(bus_addr_i, `ACGR_S2_LOW_ADDR))
			rdata_d = s2_low_q;
	end

	always @(posedge sys_clk_i)
	begin
		if (reset_i)
			bus_rdata_o <= `ACGR_UNMAPPED_DATA;
		else
			bus_rdata_o <= rdata_d;
	end

endmodule // acgr_regs

// ---- test/acgr_regs_properties.sv ----
// Checker: byte-to-word mapping, capture hold, unmapped reads.
// Assumes it is bound onto acgr_regs.
`timescale 1ns/10ps
module acgr_props
(
	input wire        sys_clk_i,
	input wire        reset_i,
	input wire [15:0] bus_addr_i,
	input wire        bus_wr_i,
	input wire [7:0]  bus_wdata_i,
	input wire [7:0]  bus_rdata_o,
	input wire        usb_sof_i,
	input wire [23:0] first_adaptive_synth_freq_word_o,
	input wire [23:0] second_adaptive_synth_freq_word_o,
	input wire [15:0] frame_count_latch_o
);
	wire [23:0] f1 = first_adaptive_synth_freq_word_o;
	wire [23:0] f2 = second_adaptive_synth_freq_word_o;
	wire [15:0] ad = bus_addr_i;
	// ----------
	// Assertions
	// ----------
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	a_s1_top_byte: assert property (bus_wr_i && ad == 16'hFFE5
		|=> ##1 f1[23:16] == $past(bus_wdata_i, 2)) else $error("s1 top byte");
	a_s1_mid_byte: assert property (bus_wr_i && ad == 16'hFFE6
		|=> ##1 f1[15:8] == $past(bus_wdata_i, 2)) else $error("s1 mid byte");
	a_s1_low_byte: assert property (bus_wr_i && ad == 16'hFFE7
		|=> ##1 f1[7:0] == $past(bus_wdata_i, 2)) else $error("s1 low byte");
	a_s2_top_byte: assert property (bus_wr_i && ad == 16'hFFF7
		|=> ##1 f2[23:16] == $past(bus_wdata_i, 2)) else $error("s2 top byte");
	a_s2_mid_byte: assert property (bus_wr_i && ad == 16'hFFF8
		|=> ##1 f2[15:8] == $past(bus_wdata_i, 2)) else $error("s2 mid byte");
	a_s2_low_byte: assert property (bus_wr_i && ad == 16'hFFF9
		|=> ##1 f2[7:0] == $past(bus_wdata_i, 2)) else $error("s2 low byte");
	a_capture_hold: assert property ($changed(frame_count_latch_o)
		|-> $past(usb_sof_i, 2)) else $error("capture moved without frame");
	a_unmapped_read: assert property (ad == 16'hFFFA
		|=> bus_rdata_o == 8'h00) else $error("unmapped read not zero");
endmodule // acgr_props

bind acgr_regs acgr_props u_props (.sys_clk_i, .reset_i, .bus_addr_i, .bus_wr_i,
	.bus_wdata_i, .bus_rdata_o, .usb_sof_i, .first_adaptive_synth_freq_word_o,
	.second_adaptive_synth_freq_word_o, .frame_count_latch_o);

// ---- test/tb_top.sv ----
// Testbench: reset values, register map, frame count capture.
// Assumes master clocks from cycle counter bits, both below 10 MHz.
`timescale 1ns/10ps
module tb_top;
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg  [15:0] addr = 16'h0000;
	reg         wr = 1'b0;
	reg  [7:0]  wd = 8'h00;
	reg         sof = 1'b0;
	reg         sel = 1'b0;
	reg         sof_en = 1'b0;
	reg  [6:0]  cyc = 7'h00;
	reg  [15:0] c0, c1;
	reg  [7:0]  b;
	wire [7:0]  rdata;
	wire [23:0] w1, w2;
	wire [15:0] cap;
	integer     n_mismatch = 0, n_tests = 0, i;
	acgr_regs dut (.sys_clk_i(clk), .reset_i(rst), .bus_addr_i(addr), .bus_wr_i(wr),
		.bus_wdata_i(wd), .bus_rdata_o(rdata), .usb_sof_i(sof),
		.primary_codec_clock_out_i(cyc[2]), .second_codec_clock_out_i(cyc[1]),
		.count_clk_sel_i(sel), .first_adaptive_synth_freq_word_o(w1),
		.second_adaptive_synth_freq_word_o(w2), .frame_count_latch_o(cap));
	initial forever #25 clk = ~clk;
	// Fixed frame spacing keeps the count per frame exact
	always @(posedge clk)
	begin
		cyc <= cyc + 7'h01;
		sof <= sof_en && cyc == 7'h7F;
	end
	// ----------
	// Tasks
	// ----------
	function [15:0] ad(input integer k);
		ad = (k < 5) ? 16'hFFE3 + k[15:0] : 16'hFFF2 + k[15:0];
	endfunction
	task test_done;
		begin
			if (n_mismatch == 0 && n_tests > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	task check(input [23:0] got, input [23:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp)
			begin
				$display("ERROR %0t got %h expected %h", $time, got, exp);
				n_mismatch = n_mismatch + 1;
			end
		end
	endtask
	task rd(input [15:0] a, output [7:0] d);
		begin
			@(posedge clk) addr <= a;
			repeat (2) @(posedge clk);
			#1 d = rdata;
		end
	endtask
	task grab(output [15:0] v);
		integer k;
		begin
			k = 0;
			while (sof !== 1'b1 && k < 300)
			begin
				@(posedge clk);
				#1 k = k + 1;
			end
			if (k >= 300)
			begin
				$display("ERROR %0t no frame pulse", $time);
				n_mismatch = n_mismatch + 1;
				test_done;
			end
			else
			begin
				repeat (3) @(posedge clk);
				rd(16'hFFE3, v[15:8]);
				rd(16'hFFE4, v[7:0]);
				check(cap, v);
			end
		end
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 8; i = i + 1)
		begin
			rd(ad(i), b);
			check(b, 8'h00);
		end
		// Back-to-back writes, read-only and unmapped places included
		for (i = 0; i < 9; i = i + 1)
		begin
			@(posedge clk);
			addr <= ad(i);
			wr <= 1'b1;
			wd <= 8'h10 + i[7:0];
		end
		@(posedge clk) wr <= 1'b0;
		repeat (2) @(posedge clk);
		#1 check(w1, 24'h121314);
		check(w2, 24'h151617);
		for (i = 0; i < 9; i = i + 1)
		begin
			rd(ad(i), b);
			check(b, (i < 2 || i > 7) ? 8'h00 : 8'h10 + i[7:0]);
		end
		sof_en <= 1'b1;
		grab(c0);
		grab(c1);
		check(c1 - c0, 16'h0010);
		@(posedge clk) sel <= 1'b1;
		grab(c0);
		grab(c0);
		grab(c1);
		check(c1 - c0, 16'h0020);
		// Mid-run reset must clear written bytes and the capture
		@(posedge clk)
		begin
			rst <= 1'b1;
			sof_en <= 1'b0;
		end
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1 check(w1, 24'h000000);
		check(w2, 24'h000000);
		check(cap, 16'h0000);
		check(rdata, 8'h00);
		test_done;
	end
endmodule // tb_top
